// file: common/zfan_defs.svh
`ifndef ZFAN_DEFS_SVH
`define ZFAN_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ZF_A_CTRL 32'h0000_0000
`define ZF_A_BIND 32'h0000_0004
`define ZF_A_MANUAL 32'h0000_0008
`define ZF_A_FLRHYS 32'h0000_000C
`define ZF_A_BASE 32'h0000_0010
`define ZF_A_TEMP0 32'h0000_0014
`define ZF_A_OFS0 32'h0000_0024
`define ZF_A_STATUS 32'h0000_0034
`define ZF_NREG 14
`define ZF_IDX_W 4
`define ZF_I_CTRL 4'h0
`define ZF_I_BIND 4'h1
`define ZF_I_MANUAL 4'h2
`define ZF_I_FLRHYS 4'h3
`define ZF_I_BASE 4'h4
`define ZF_I_TEMP0 4'h5
`define ZF_I_TEMP3 4'h8
`define ZF_I_OFS0A 4'h9
`define ZF_I_OFS0B 4'hA
`define ZF_I_OFS1A 4'hB
`define ZF_I_OFS1B 4'hC
`define ZF_I_STATUS 4'hD

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define ZF_CTRL_HALF0 0
`define ZF_CTRL_HALF1 1
`define ZF_CTRL_LOW0 2
`define ZF_CTRL_OVR0 4
`define ZF_MASK_CTRL 32'h0000_003F
`define ZF_MASK_BYTE 32'h0000_00FF
`define ZF_MASK_HALF 32'h0000_FFFF
`define ZF_MASK_T9 32'h0000_01FF
`define ZF_MASK_ALL 32'hFFFF_FFFF
`define ZF_MASK_NONE 32'h0000_0000
`define ZF_RESET_WORD 32'h0000_0000

// ----------------------------------------------------------------------
// Duty codes and timing
// ----------------------------------------------------------------------
`define ZF_CODE_MIN 4'h1
`define ZF_CODE_FULL 4'hD
`define ZF_NSTEP 12
`define ZF_HF_SLOTS 16
`define ZF_LF_SLOTS 28
`define ZF_CLK_HZ 25000000
`define ZF_HF_HZ 22500
`define ZF_LF_HZ 100
`define ZF_HF_SLOT_CYC ((`ZF_CLK_HZ + `ZF_HF_HZ * `ZF_HF_SLOTS - 1) / \
	(`ZF_HF_HZ * `ZF_HF_SLOTS))
`define ZF_LF_SLOT_CYC ((`ZF_CLK_HZ + `ZF_LF_HZ * `ZF_LF_SLOTS - 1) / \
	(`ZF_LF_HZ * `ZF_LF_SLOTS))
`define ZF_RESP_OKAY 2'b00
`define ZF_RESP_SLVERR 2'b10

`endif

// file: common/zfan_pkg.sv
package zfan_pkg;
	typedef logic [3:0] zfan_code_t;
	typedef logic [10:0] zfan_temp_t;
	typedef logic [47:0] zfan_ofs_t;
endpackage

// file: common/zfan_pwm_if.sv
interface zfan_pwm_if;
	zfan_pkg::zfan_code_t duty_code;
	logic low_freq;
	logic pwm;
	modport ctl (output duty_code, output low_freq, input pwm);
	modport gen (input duty_code, input low_freq, output pwm);
endinterface

// file: rtl/zfan_pwm.sv
`include "zfan_defs.svh"

module zfan_pwm #(
	parameter int HF_SLOT_CYC = `ZF_HF_SLOT_CYC,
	parameter int LF_SLOT_CYC = `ZF_LF_SLOT_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Duty request and output
	zfan_pwm_if.gen port
);
	if (HF_SLOT_CYC < 1 || LF_SLOT_CYC < 1 ||
		LF_SLOT_CYC > 65535) begin : g_bad_slot
		$error("zfan_pwm: slot length out of range.");
	end

	logic [15:0] pre_q;
	logic [4:0] slot_q;
	logic [4:0] num_q;
	logic low_q;
	logic pwm_q;
	logic [15:0] pre_end;
	logic [4:0] slot_end;
	logic period_end;

	// ------------------------------------------------------------------
	// Code to active slots per period
	// ------------------------------------------------------------------
	function automatic logic [4:0] slots_of(zfan_pkg::zfan_code_t c,
		logic low);
		logic [4:0] n;
		n = 5'd0;
		if (c == 4'h0) begin
			n = 5'd0;
		end else if (c > `ZF_CODE_FULL) begin
			n = low ? 5'(`ZF_LF_SLOTS) : 5'(`ZF_HF_SLOTS);
		end else if (!low) begin
			n = 5'(c) + 5'd3;
		end else if (c <= 4'hA) begin
			n = 5'(c) + 5'd6;
		end else begin
			n = 5'd20 + 5'((c - 4'hB) << 2);
		end
		return n;
	endfunction

	// ------------------------------------------------------------------
	// Period timing
	// ------------------------------------------------------------------
	assign pre_end = low_q ? 16'(LF_SLOT_CYC - 1) : 16'(HF_SLOT_CYC - 1);
	assign slot_end = low_q ? 5'(`ZF_LF_SLOTS - 1) : 5'(`ZF_HF_SLOTS - 1);
	assign period_end = (pre_q == pre_end) && (slot_q == slot_end);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= 16'h0000;
			slot_q <= 5'h00;
		end else if (pre_q >= pre_end) begin
			pre_q <= 16'h0000;
			slot_q <= (slot_q >= slot_end) ? 5'h00 : slot_q + 5'h01;
		end else begin
			pre_q <= pre_q + 16'h0001;
		end
	end

	// New code and frequency are taken only at a period boundary so that
	// a change never produces a runt pulse.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			num_q <= 5'h00;
			low_q <= 1'b0;
		end else if (period_end) begin
			num_q <= slots_of(port.duty_code, port.low_freq);
			low_q <= port.low_freq;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwm_q <= 1'b0;
		end else begin
			pwm_q <= slot_q < num_q;
		end
	end

	assign port.pwm = pwm_q;
endmodule

// file: rtl/zfan_top.sv
// Functional notes
// - PWM up to 22.5 kHz, 6.25% steps.
// - Twelve offsets, per-zone base, fixed step duties.
// - Zones 1/2 and 3/4 share offset sets.
// - One hysteresis per offset set.
// - Thresholds are cumulative offsets over base.
// - At or below base gives floor duty.
// - Zero offset step is skipped over.
// - Half-degree mode halves offset and hysteresis LSB.
// - Zones 1-3 nine bits; zone 4 left-justified.
// - Only bound zones drive an output.
// - Step duty depends on output frequency.
// - High-frequency code map, 25% plus 6.25% steps.
// - Low-frequency code map in 28ths.
// - Low frequency select switches duty mapping.
// - One shared code map, fourteen steps.
// - Interval search; last threshold gives 100%.
// - Lookup is one of several duty requests.
// - Final duty is maximum per override priority.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`include "zfan_defs.svh"

module zfan_top #(
	parameter int LF_SLOT_CYC = `ZF_LF_SLOT_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Other duty requests: a force flag shared by both outputs, then one code per output
	input wire logic force_full,
	input wire logic [7:0] regulator_overheat_duty,
	input wire logic [7:0] processor_throttle_duty,
	input wire logic [7:0] spinup_duty,
	// PWM outputs
	output logic [1:0] pwm_out
);
	localparam int HF_SLOT_CYC = `ZF_HF_SLOT_CYC;

	if (LF_SLOT_CYC < HF_SLOT_CYC || LF_SLOT_CYC > 65535) begin : g_bad_lf
		$error("zfan_top: LF_SLOT_CYC out of range.");
	end

	logic [31:0] regs_q [`ZF_NREG];
	zfan_pkg::zfan_code_t zone_code_q [4];
	zfan_pkg::zfan_code_t final_code [2];
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_have_q;
	logic w_have_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic do_write;
	logic [31:0] w_mask;

	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------
	function automatic logic addr_ok(logic [31:0] a);
		logic ok;
		ok = 1'b0;
		if (a[1:0] != 2'b00) begin
			ok = 1'b0;
		end else if (a > `ZF_A_STATUS) begin
			ok = 1'b0;
		end else begin
			ok = 1'b1;
		end
		return ok;
	endfunction

	function automatic logic [`ZF_IDX_W-1:0] addr_idx(logic [31:0] a);
		return a[`ZF_IDX_W+1:2];
	endfunction

	function automatic logic [31:0] wmask(logic [`ZF_IDX_W-1:0] i);
		logic [31:0] m;
		m = `ZF_MASK_NONE;
		if (i == `ZF_I_CTRL) begin
			m = `ZF_MASK_CTRL;
		end else if (i == `ZF_I_BIND || i == `ZF_I_MANUAL) begin
			m = `ZF_MASK_BYTE;
		end else if (i == `ZF_I_FLRHYS) begin
			m = `ZF_MASK_HALF;
		end else if (i == `ZF_I_BASE) begin
			m = `ZF_MASK_ALL;
		end else if (i == `ZF_I_TEMP3) begin
			m = `ZF_MASK_BYTE;
		end else if (i >= `ZF_I_TEMP0 && i < `ZF_I_TEMP3) begin
			m = `ZF_MASK_T9;
		end else if (i == `ZF_I_OFS0A || i == `ZF_I_OFS1A) begin
			m = `ZF_MASK_ALL;
		end else if (i == `ZF_I_OFS0B || i == `ZF_I_OFS1B) begin
			m = `ZF_MASK_HALF;
		end
		return m;
	endfunction

	function automatic zfan_pkg::zfan_code_t cmax(zfan_pkg::zfan_code_t a,
		zfan_pkg::zfan_code_t b);
		return (a > b) ? a : b;
	endfunction

	// Step code for a temperature in half-degree units. Step k+1 starts
	// where the offsets below it sum to; zero-width steps are passed over.
	function automatic zfan_pkg::zfan_code_t step_code(
		zfan_pkg::zfan_temp_t t, logic [7:0] base, zfan_pkg::zfan_ofs_t ofs,
		logic half, zfan_pkg::zfan_code_t floor_c);
		zfan_pkg::zfan_temp_t s;
		zfan_pkg::zfan_temp_t b;
		zfan_pkg::zfan_code_t c;
		b = {2'b00, base, 1'b0};
		s = b;
		c = `ZF_CODE_MIN;
		for (int k = 0; k < `ZF_NSTEP; k++) begin
			s = s + (half ? {7'h00, ofs[4*k +: 4]} :
				{6'h00, ofs[4*k +: 4], 1'b0});
			if (t >= s) begin
				c = c + 4'h1;
			end
		end
		// Passing every threshold ends at the full-duty code.
		if (t <= b) begin
			c = floor_c;
		end else begin
			c = cmax(c, floor_c);
		end
		return c;
	endfunction

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign w_mask = wmask(addr_idx(aw_addr_q));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `ZF_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= addr_ok(aw_addr_q) ? `ZF_RESP_OKAY : `ZF_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Register file; writes merge under the byte strobes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `ZF_NREG; i++) begin
				regs_q[i] <= `ZF_RESET_WORD;
			end
		end else if (do_write && addr_ok(aw_addr_q)) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb_q[b]) begin
					regs_q[addr_idx(aw_addr_q)][8*b +: 8] <=
						w_data_q[8*b +: 8] & w_mask[8*b +: 8];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= `ZF_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			if (!addr_ok(s_axi_araddr)) begin
				rresp_q <= `ZF_RESP_SLVERR;
				rdata_q <= 32'h0000_0000;
			end else if (addr_idx(s_axi_araddr) == `ZF_I_STATUS) begin
				rresp_q <= `ZF_RESP_OKAY;
				rdata_q <= {8'h00, final_code[1], final_code[0],
					zone_code_q[3], zone_code_q[2],
					zone_code_q[1], zone_code_q[0]};
			end else begin
				rresp_q <= `ZF_RESP_OKAY;
				rdata_q <= regs_q[addr_idx(s_axi_araddr)];
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Zone lookup with hysteresis
	// ------------------------------------------------------------------
	zfan_pkg::zfan_ofs_t tbl_ofs [2];
	assign tbl_ofs[0] = {regs_q[`ZF_I_OFS0B][15:0], regs_q[`ZF_I_OFS0A]};
	assign tbl_ofs[1] = {regs_q[`ZF_I_OFS1B][15:0], regs_q[`ZF_I_OFS1A]};

	for (genvar z = 0; z < 4; z++) begin : g_zone
		localparam int T = z / 2;
		logic half;
		logic [3:0] hyst;
		zfan_pkg::zfan_code_t floor_c;
		zfan_pkg::zfan_temp_t temp;
		zfan_pkg::zfan_temp_t temp_h;
		zfan_pkg::zfan_code_t up_c;
		zfan_pkg::zfan_code_t dn_c;
		assign half = regs_q[`ZF_I_CTRL][`ZF_CTRL_HALF0 + T];
		assign hyst = regs_q[`ZF_I_FLRHYS][8 + 4*T +: 4];
		assign floor_c = regs_q[`ZF_I_FLRHYS][4*T +: 4];
		if (z == 3) begin : g_z4
			// Eight-bit whole degrees, left-justified into half units.
			assign temp = {2'b00, regs_q[`ZF_I_TEMP3][7:0], 1'b0};
		end else begin : g_z9
			assign temp = half ? {2'b00, regs_q[`ZF_I_TEMP0 + z][8:0]} :
				{2'b00, regs_q[`ZF_I_TEMP0 + z][8:1], 1'b0};
		end
		assign temp_h = temp + (half ? {7'h00, hyst} : {6'h00, hyst, 1'b0});
		assign up_c = step_code(temp, regs_q[`ZF_I_BASE][8*z +: 8],
			tbl_ofs[T], half, floor_c);
		assign dn_c = step_code(temp_h, regs_q[`ZF_I_BASE][8*z +: 8],
			tbl_ofs[T], half, floor_c);

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				zone_code_q[z] <= 4'h0;
			end else if (up_c > zone_code_q[z]) begin
				zone_code_q[z] <= up_c;
			end else if (dn_c < zone_code_q[z]) begin
				zone_code_q[z] <= dn_c;
			end
		end
	end

	// ------------------------------------------------------------------
	// Per-output arbitration and PWM generation
	// ------------------------------------------------------------------
	for (genvar p = 0; p < 2; p++) begin : g_out
		zfan_pkg::zfan_code_t auto_c;
		zfan_pkg::zfan_code_t common_c;
		logic [3:0] bind_m;
		logic ovr;
		zfan_pwm_if pif ();
		assign bind_m = regs_q[`ZF_I_BIND][4*p +: 4];
		assign ovr = regs_q[`ZF_I_CTRL][`ZF_CTRL_OVR0 + p];

		always_comb begin
			auto_c = 4'h0;
			for (int z = 0; z < 4; z++) begin
				if (bind_m[z]) begin
					auto_c = cmax(auto_c, zone_code_q[z]);
				end
			end
		end

		// Codes are compared, not duties: both maps rise with the code.
		assign common_c = cmax(force_full ? `ZF_CODE_FULL : 4'h0,
			cmax(regulator_overheat_duty[4*p +: 4],
			processor_throttle_duty[4*p +: 4]));
		assign final_code[p] = ovr ?
			cmax(common_c, regs_q[`ZF_I_MANUAL][4*p +: 4]) :
			cmax(common_c, cmax(auto_c, spinup_duty[4*p +: 4]));

		assign pif.duty_code = final_code[p];
		assign pif.low_freq = regs_q[`ZF_I_CTRL][`ZF_CTRL_LOW0 + p];
		assign pwm_out[p] = pif.pwm;

		zfan_pwm #(
			.HF_SLOT_CYC(HF_SLOT_CYC),
			.LF_SLOT_CYC(LF_SLOT_CYC)
		) u_pwm (
			.aclk(aclk),
			.aresetn(aresetn),
			.port(pif.gen)
		);
	end
endmodule

// file: sim/zfan_top_sva.sv
// ------------------------------
// Port checker
// ------------------------------
module zfan_top_sva #(
	parameter int LF_SLOT_CYC = 70
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Duty side
	input wire logic force_full,
	input wire logic [1:0] pwm_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FW = 56 * LF_SLOT_CYC + 2;
	logic p0_q, seen_q;
	logic [15:0] hi_q, rr_q;
	int fc_q;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Length of the current high run on output 0.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p0_q <= 1'b0;
			hi_q <= 16'h0000;
		end else begin
			p0_q <= pwm_out[0];
			if (!pwm_out[0])
				hi_q <= 16'h0000;
			else if (hi_q != 16'hFFFF)
				hi_q <= hi_q + 16'h0001;
		end
	end

	// Cycles since the last rising edge on output 0.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen_q <= 1'b0;
			rr_q <= 16'h0000;
		end else if (pwm_out[0] && !p0_q) begin
			seen_q <= 1'b1;
			rr_q <= 16'h0001;
		end else if (rr_q != 16'hFFFF) begin
			rr_q <= rr_q + 16'h0001;
		end
	end

	// Cycles the force request has been held, saturating.
	always_ff @(posedge aclk) begin
		if (!aresetn || !force_full)
			fc_q <= 0;
		else if (fc_q < FW)
			fc_q <= fc_q + 1;
	end

	a_rd_latency: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_release: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	a_wr_latency: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	a_wr_release: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not released");
	a_reset_clears: assert property ($rose(aresetn) |->
		pwm_out == 2'b00 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not cleared by reset");
	a_force_full: assert property (
		fc_q == FW |-> pwm_out == 2'b11)
		else $error("forced full duty not reached");
	a_min_pulse: assert property (
		$fell(pwm_out[0]) |-> hi_q >= 16'h0118)
		else $error("high pulse shorter than lowest step");
	a_period_floor: assert property (
		pwm_out[0] && !p0_q && seen_q |-> rr_q >= 16'h0460)
		else $error("pwm period too short");
endmodule

bind zfan_top zfan_top_sva #(.LF_SLOT_CYC(LF_SLOT_CYC)) zfan_top_sva_inst (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.force_full, .pwm_out
);

// file: sim/zfan_fan_stage.sv
// ------------------------------
// Fan power stage model
// ------------------------------
module zfan_fan_stage (
	// Clock
	input wire logic aclk,
	// Drive from the block
	input wire logic pwm,
	// High time of the last period, and its strobe
	output logic [15:0] hi_cnt,
	output logic done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev = 1'b0;
	logic [15:0] acc = 16'h0000;

	// Each rising edge closes a period; the filter sees its high time.
	always @(posedge aclk) begin
		prev <= pwm;
		done <= pwm && !prev;
		if (pwm && !prev) begin
			hi_cnt <= acc;
			acc <= 16'h0001;
		end else begin
			acc <= acc + {15'h0000, pwm};
		end
	end
endmodule

// file: sim/zone_lookup_fan_pwm_control_test.sv
`include "zfan_defs.svh"

module zone_lookup_fan_pwm_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, force_full, done;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, pwm_out;
	logic [7:0] regulator_overheat_duty, processor_throttle_duty;
	logic [7:0] spinup_duty;
	logic [15:0] hi_cnt;
	logic [33:0] q_rd[$], q_b[$], q_pw[$];
	int fail_count, compares;

	zfan_top #(.LF_SLOT_CYC(70)) zfan_top_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .force_full,
		.regulator_overheat_duty, .processor_throttle_duty,
		.spinup_duty, .pwm_out
	);
	zfan_fan_stage zfan_fan_stage_inst (.aclk, .pwm(pwm_out[0]),
		.hi_cnt, .done);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ------------------------------
	// Checking and bus tasks
	// ------------------------------
	task tally_and_finish;
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task hang;
		fail_count++;
		$display("FAIL %0t wait timed out", $time);
		tally_and_finish();
	endtask

	task cmp(input string k, input logic [33:0] g, e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %0t %s got %h expected %h", $time, k, g, e);
		end
	endtask

	task cmp_read(input logic [33:0] g, e);
		cmp("read", g, e);
	endtask

	task cmp_resp(input logic [33:0] g, e);
		cmp("wresp", g, e);
	endtask

	task cmp_duty(input logic [33:0] g, e);
		cmp("duty", g, e);
	endtask

	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			cmp_read({s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			cmp_resp({32'h0, s_axi_bresp}, q_b.pop_front());
		if (done && q_pw.size() > 0)
			cmp_duty({18'h0, hi_cnt}, q_pw.pop_front());
	end

	task wr(input logic [31:0] a, d, input logic [1:0] r);
		q_b.push_back({32'h0, r});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	task rd(input logic [31:0] a, input logic [33:0] e);
		q_rd.push_back(e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	task st(input logic [3:0] o1, o0, z4, z2, z1);
		rd(`ZF_A_STATUS, {`ZF_RESP_OKAY, 8'h00, o1, o0, z4, 4'h0, z2, z1});
	endtask

	task zt(input logic [31:0] t, input logic [3:0] o1, o0, z1);
		wr(`ZF_A_TEMP0, t, `ZF_RESP_OKAY);
		st(o1, o0, 4'hB, 4'h5, z1);
	endtask

	// Skip the period in flight and the first new one, then note one.
	task meas(input logic [15:0] e);
		int k;
		k = 0;
		for (int n = 0; n < 9000 && k < 2; n++) begin
			@(posedge aclk);
			if (done)
				k++;
		end
		if (k < 2)
			hang();
		@(negedge aclk);
		q_pw.push_back({18'h0, e});
		for (int n = 0; n < 3000 && q_pw.size() > 0; n++)
			@(posedge aclk);
		if (q_pw.size() > 0)
			hang();
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		logic [31:0] r;
		logic [3:0] a, b, c, m;
		aresetn = 1'b0;
		force_full = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		{regulator_overheat_duty, processor_throttle_duty} = 16'h0;
		spinup_duty = 8'h00;
		r = $urandom(32'hD49889B4);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`ZF_A_CTRL, {`ZF_RESP_OKAY, 32'h0});
		rd(32'h0000_0038, {`ZF_RESP_SLVERR, 32'h0});
		wr(32'h0000_0002, 32'h1, `ZF_RESP_SLVERR);
		wr(`ZF_A_STATUS, 32'hFFFF_FFFF, `ZF_RESP_OKAY);
		rd(`ZF_A_STATUS, {`ZF_RESP_OKAY, 32'h0});
		r = $urandom();
		wr(`ZF_A_CTRL, r, `ZF_RESP_OKAY);
		rd(`ZF_A_CTRL, {`ZF_RESP_OKAY, r & `ZF_MASK_CTRL});
		wr(`ZF_A_CTRL, 32'h3, `ZF_RESP_OKAY);
		wr(`ZF_A_FLRHYS, 32'h0405, `ZF_RESP_OKAY);
		wr(`ZF_A_BASE, 32'h2300_0046, `ZF_RESP_OKAY);
		wr(`ZF_A_OFS0, 32'h4310_0000, `ZF_RESP_OKAY);
		wr(32'h0000_0028, 32'h3320, `ZF_RESP_OKAY);
		wr(32'h0000_002C, 32'h2222_2222, `ZF_RESP_OKAY);
		wr(32'h0000_0030, 32'h2222, `ZF_RESP_OKAY);
		wr(`ZF_A_BIND, 32'h91, `ZF_RESP_OKAY);
		wr(32'h0000_0020, 32'h0, `ZF_RESP_OKAY);
		st(4'h5, 4'h5, 4'h0, 4'h5, 4'h5);
		wr(`ZF_A_TEMP0, 32'h8B, `ZF_RESP_OKAY);
		st(4'h5, 4'h5, 4'h0, 4'h5, 4'h5);
		wr(`ZF_A_TEMP0, 32'h8E, `ZF_RESP_OKAY);
		st(4'h7, 4'h7, 4'h0, 4'h5, 4'h7);
		wr(`ZF_A_TEMP0, 32'h94, `ZF_RESP_OKAY);
		st(4'hA, 4'hA, 4'h0, 4'h5, 4'hA);
		meas(16'h038E);
		wr(`ZF_A_CTRL, 32'h7, `ZF_RESP_OKAY);
		meas(16'h0460);
		wr(`ZF_A_CTRL, 32'h3, `ZF_RESP_OKAY);
		wr(32'h0000_0020, 32'h24, `ZF_RESP_OKAY);
		st(4'hA, 4'hA, 4'h2, 4'h5, 4'hA);
		wr(32'h0000_0020, 32'h2D, `ZF_RESP_OKAY);
		st(4'hB, 4'hA, 4'hB, 4'h5, 4'hA);
		repeat (4) begin
			a = 4'($urandom_range(13));
			b = 4'($urandom_range(13));
			c = 4'($urandom_range(13));
			m = 4'hA;
			m = (a > m) ? a : m;
			m = (b > m) ? b : m;
			m = (c > m) ? c : m;
			regulator_overheat_duty <= {4'h0, a};
			processor_throttle_duty <= {4'h0, b};
			spinup_duty <= {4'h0, c};
			st(4'hB, m, 4'hB, 4'h5, 4'hA);
		end
		regulator_overheat_duty <= 8'h00;
		processor_throttle_duty <= 8'h00;
		spinup_duty <= 8'h0C;
		wr(`ZF_A_MANUAL, 32'h3, `ZF_RESP_OKAY);
		wr(`ZF_A_CTRL, 32'h13, `ZF_RESP_OKAY);
		st(4'hB, 4'h3, 4'hB, 4'h5, 4'hA);
		processor_throttle_duty <= 8'h05;
		st(4'hB, 4'h5, 4'hB, 4'h5, 4'hA);
		wr(`ZF_A_CTRL, 32'h3, `ZF_RESP_OKAY);
		processor_throttle_duty <= 8'h00;
		spinup_duty <= 8'h00;
		force_full <= 1'b1;
		st(4'hD, 4'hD, 4'hB, 4'h5, 4'hA);
		repeat (4000) @(posedge aclk);
		force_full <= 1'b0;
		zt(32'h92, 4'hB, 4'hA, 4'hA);
		zt(32'h8D, 4'hB, 4'h8, 4'h8);
		zt(32'h9C, 4'hD, 4'hD, 4'hD);
		wr(`ZF_A_CTRL, 32'h2, `ZF_RESP_OKAY);
		st(4'hB, 4'hB, 4'hB, 4'h5, 4'hB);
		tally_and_finish();
	end
endmodule
